// file: rtl/ucc_pkg.sv
// Constants for one serial channel's control and status registers.
// Assumes a 32-bit classic Wishbone bus with registers in byte lane 0.
package ucc_pkg;

    // Register byte addresses
    localparam logic [7:0] UCC_ADR_CAUSE    = 8'h00;
    localparam logic [7:0] UCC_ADR_SETUP    = 8'h04;
    localparam logic [7:0] UCC_ADR_FORMAT   = 8'h08;
    localparam logic [7:0] UCC_ADR_INT_EN   = 8'h0C;
    localparam logic [7:0] UCC_ADR_ENHANCED = 8'h10;
    localparam logic [7:0] UCC_ADR_FEATURE  = 8'h14;
    localparam logic [7:0] UCC_ADR_TX_PROG  = 8'h18;
    localparam logic [7:0] UCC_ADR_RX_PROG  = 8'h1C;
    localparam logic [7:0] UCC_ADR_LAST_FC  = 8'h20;

    // fifo_setup fields
    localparam int UCC_SETUP_EN     = 0;
    localparam int UCC_SETUP_RX_CLR = 1;
    localparam int UCC_SETUP_TX_CLR = 2;
    localparam int UCC_SETUP_BLOCK  = 3;
    localparam int UCC_SETUP_TX_LSB = 4;
    localparam int UCC_SETUP_RX_LSB = 6;

    // Other field positions
    localparam int UCC_ENH_BIT     = 4;
    localparam int UCC_FEAT_TABLE  = 6;
    localparam int UCC_IE_RX       = 0;
    localparam int UCC_IE_TX       = 1;
    localparam int UCC_IE_LINE     = 2;
    localparam int UCC_IE_MODEM    = 3;
    localparam int UCC_IE_FLOW     = 5;
    localparam int UCC_IE_RTS      = 6;
    localparam int UCC_IE_CTS      = 7;
    localparam int UCC_FMT_LEN_LSB = 0;
    localparam int UCC_FMT_STOP    = 2;
    localparam int UCC_FMT_PAR_EN  = 3;
    localparam int UCC_FMT_EVEN    = 4;
    localparam int UCC_FMT_FORCE   = 5;

    // Reset values
    localparam logic [7:0] UCC_RST_BYTE  = 8'h00;
    localparam logic [6:0] UCC_RST_PROG  = 7'h01;

    // Cause codes, bits 5:0
    localparam logic [5:0] UCC_CAUSE_LINE    = 6'h06;
    localparam logic [5:0] UCC_CAUSE_RX      = 6'h04;
    localparam logic [5:0] UCC_CAUSE_TIMEOUT = 6'h0C;
    localparam logic [5:0] UCC_CAUSE_TX      = 6'h02;
    localparam logic [5:0] UCC_CAUSE_MODEM   = 6'h00;
    localparam logic [5:0] UCC_CAUSE_FLOW    = 6'h10;
    localparam logic [5:0] UCC_CAUSE_CHANGE  = 6'h20;
    localparam logic [5:0] UCC_CAUSE_NONE    = 6'h01;

    // Trigger tables, entry index is the 2-bit select
    localparam logic [1:0] UCC_TABLE_A = 2'h0;
    localparam logic [1:0] UCC_TABLE_B = 2'h1;
    localparam logic [1:0] UCC_TABLE_C = 2'h2;
    localparam logic [3:0][6:0] UCC_RX_TAB_A = {7'h0E, 7'h08, 7'h04, 7'h01};
    localparam logic [6:0]      UCC_TX_TAB_A = 7'h01;
    localparam logic [3:0][6:0] UCC_RX_TAB_B = {7'h1C, 7'h18, 7'h10, 7'h08};
    localparam logic [3:0][6:0] UCC_TX_TAB_B = {7'h1E, 7'h18, 7'h08, 7'h10};
    localparam logic [3:0][6:0] UCC_RX_TAB_C = {7'h3C, 7'h38, 7'h10, 7'h08};
    localparam logic [3:0][6:0] UCC_TX_TAB_C = {7'h38, 7'h20, 7'h10, 7'h08};

    // Character lengths and parity kinds
    localparam logic [3:0] UCC_MIN_BITS   = 4'h5;
    localparam logic [1:0] UCC_PAR_ODD    = 2'h0;
    localparam logic [1:0] UCC_PAR_EVEN   = 2'h1;
    localparam logic [1:0] UCC_PAR_MARK   = 2'h2;
    localparam logic [1:0] UCC_PAR_SPACE  = 2'h3;

endpackage

// file: rtl/ucc_trigger_lookup.sv
// Trigger level lookup for the shared receive and transmit table.
// Combinational; the caller registers the levels.
module ucc_trigger_lookup
    import ucc_pkg::*;
(
    input  wire logic [1:0] table_i,   // Shared table select
    input  wire logic [1:0] rx_sel_i,  // Receive level select
    input  wire logic [1:0] tx_sel_i,  // Transmit level select
    input  wire logic [6:0] rx_prog_i, // Programmable receive level
    input  wire logic [6:0] tx_prog_i, // Programmable transmit level
    output logic      [6:0] rx_lvl_o,  // Receive trigger level
    output logic      [6:0] tx_lvl_o   // Transmit trigger level
);

    // Shared table: the latest choice applies to both directions
    always_comb
    begin
        if (table_i == UCC_TABLE_A)  // [R13] [R14]
        begin
            rx_lvl_o = UCC_RX_TAB_A[rx_sel_i];
            tx_lvl_o = UCC_TX_TAB_A;
        end
        else if (table_i == UCC_TABLE_B)
        begin
            rx_lvl_o = UCC_RX_TAB_B[rx_sel_i];
            tx_lvl_o = UCC_TX_TAB_B[tx_sel_i];
        end
        else if (table_i == UCC_TABLE_C)
        begin
            rx_lvl_o = UCC_RX_TAB_C[rx_sel_i];
            tx_lvl_o = UCC_TX_TAB_C[tx_sel_i];
        end
        else
        begin
            rx_lvl_o = rx_prog_i;
            tx_lvl_o = tx_prog_i;
        end
    end

endmodule

// file: rtl/ucc_channel_ctrl.sv
// Control and status registers of one serial channel:
// cause, FIFO setup, character format, enables, tables.
// Assumes a classic Wishbone master and a datapath on clk_i;
// flow pins arrive asynchronously.
//
// Overview of operation
// [R1] Cause bit 0 low while an enabled interrupt pends; reset 1.
// [R2] Cause bits 3:1 name the top pending source, levels one to four.
// [R3] Enhanced on: bit 4 flags Xon/Xoff match; cause read clears.
// [R4] Special match in bit 4 clears on cause read or next character.
// [R5] Enhanced on: bit 5 flags a rising CTS or RTS line.
// [R6] Cause bits 7:6 are 11 with FIFOs on, else 00.
// [R7] Setup bit 0 enables FIFOs, reset 0; gates the other bits.
// [R8] Setup bit 1 clears receive FIFO count, then self-clears.
// [R9] Setup bit 2 clears transmit FIFO count, then self-clears.
// [R10] Setup bit 3 block mode is stored only.
// [R11] Tx interrupt below trigger, or on empty after a low reload.
// [R12] Tx trigger select writable only while the enhanced bit is 1.
// [R13] Feature bits 7:6 pick one table shared by both directions.
// [R14] Tables A, B, C fixed; table D programmable.
// [R15] Reset selects 0: both triggers 1.
// [R16] Format bits 1:0 give 5 to 8 data bits.
// [R17] Format bit 2: 1.5 stop bits at length 5, else two.
// [R18] Format bit 3 adds parity on transmit, checks on receive.
// [R19] Format bit 4: odd (0) or even (1) parity unless forced.
// [R20] Format bit 5 forces parity: 1 if bit 4 is 0, else 0.
// [R21] Cause priority: line, rx, timeout, tx, modem, flow, change.
// [R22] A cause read clears a pending transmit-ready interrupt.
// [R23] FIFOs off: clears and triggers inactive; single holding.
module ucc_channel_ctrl
    import ucc_pkg::*;
(
    input  wire logic        clk_i,          // 200 MHz clock
    input  wire logic        rst_i,          // Synchronous reset, active high
    input  wire logic        wb_cyc_i,       // Wishbone cycle
    input  wire logic        wb_stb_i,       // Wishbone strobe
    input  wire logic        wb_we_i,        // Wishbone write enable
    input  wire logic [7:0]  wb_adr_i,       // Wishbone byte address
    input  wire logic [3:0]  wb_sel_i,       // Wishbone byte selects
    input  wire logic [31:0] wb_dat_i,       // Wishbone write data
    output logic      [31:0] wb_dat_o,       // Wishbone read data
    output logic             wb_ack_o,       // Wishbone acknowledge
    input  wire logic [6:0]  rx_level_i,     // Receive FIFO count
    input  wire logic [6:0]  tx_level_i,     // Transmit FIFO count
    input  wire logic        rx_timeout_i,   // Receive idle timeout level
    input  wire logic        line_err_i,     // Line state error level
    input  wire logic        modem_change_i, // Modem line state change level
    input  wire logic        modem_read_i,   // Pulse: modem line state read
    input  wire logic        rx_char_i,      // Pulse: character received
    input  wire logic        flow_match_i,   // Pulse: Xon or Xoff matched
    input  wire logic        flow_is_xoff_i, // Matched character was Xoff
    input  wire logic        special_i,      // Pulse: special character matched
    input  wire logic        cts_pin_i,      // CTS line, asynchronous
    input  wire logic        rts_pin_i,      // RTS line, asynchronous
    output logic             fifo_enable_o,  // FIFOs enabled
    output logic             rx_fifo_clr_o,  // Pulse: clear receive FIFO
    output logic             tx_fifo_clr_o,  // Pulse: clear transmit FIFO
    output logic      [6:0]  rx_trigger_o,   // Receive trigger level
    output logic      [6:0]  tx_trigger_o,   // Transmit trigger level
    output logic      [3:0]  data_bits_o,    // Data bits, 5 to 8
    output logic             stop_half_o,    // 1.5 stop bits
    output logic             stop_two_o,     // 2 stop bits
    output logic             parity_en_o,    // Parity bit present
    output logic      [1:0]  parity_kind_o   // Odd, even, mark, space
);

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic        fifo_en;
        logic        block_mode;
        logic [1:0]  rx_sel;
        logic [1:0]  tx_sel;
        logic [7:0]  format;
        logic [7:0]  int_en;
        logic [7:0]  enhanced;
        logic [7:0]  feature;
        logic [6:0]  tx_prog;
        logic [6:0]  rx_prog;
        logic        last_xoff;
        logic        tx_pend;
        logic        flow_pend;
        logic        spec_pend;
        logic        cts_pend;
        logic        rts_pend;
        logic [2:0]  cts_sync;
        logic [2:0]  rts_sync;
        logic        cts_st;
        logic        rts_st;
        logic [6:0]  tx_prev;
        logic        tx_above;
        logic        rx_clr;
        logic        tx_clr;
        logic [6:0]  rx_trig;
        logic [6:0]  tx_trig;
        logic [3:0]  data_bits;
        logic        stop_half;
        logic        stop_two;
        logic        par_en;
        logic [1:0]  par_kind;
    } ucc_state_type;

    ucc_state_type state;
    ucc_state_type next_state;

    logic [6:0] lut_rx;
    logic [6:0] lut_tx;

    // Settled level once the second and third stages agree
    function automatic logic settle(input logic [2:0] sync, input logic prev);
        settle = (sync[1] == sync[2]) ? sync[2] : prev;
    endfunction

    ucc_trigger_lookup u_lookup (
        .table_i   (state.feature[UCC_FEAT_TABLE +: 2]),
        .rx_sel_i  (state.rx_sel),
        .tx_sel_i  (state.tx_sel),
        .rx_prog_i (state.rx_prog),
        .tx_prog_i (state.tx_prog),
        .rx_lvl_o  (lut_rx),
        .tx_lvl_o  (lut_tx)
    );

    always_comb
    begin
        logic       req;
        logic       wr;
        logic       rd_cause;
        logic [7:0] wbyte;
        logic       enh;
        logic [6:0] rx_eff;
        logic [6:0] tx_eff;
        logic       src_line;
        logic       src_rx;
        logic       src_tmo;
        logic       src_tx;
        logic       src_mdm;
        logic       src_flow;
        logic       src_chg;
        logic [5:0] cause;
        logic [7:0] cause_byte;
        logic       tx_fall;
        logic       tx_empty;
        logic       cts_new;
        logic       rts_new;
        logic [7:0] rbyte;

        next_state = state;
        req   = wb_cyc_i & wb_stb_i & ~state.ack;
        wr    = req & wb_we_i & wb_sel_i[0];
        wbyte = wb_dat_i[7:0];
        enh   = state.enhanced[UCC_ENH_BIT];

        // Holding-register mode behaves as a trigger of one
        rx_eff = state.fifo_en ? lut_rx : UCC_RST_PROG;  // [R23]
        tx_eff = state.fifo_en ? lut_tx : UCC_RST_PROG;  // [R23]

        src_line = state.int_en[UCC_IE_LINE] & line_err_i;
        src_rx   = state.int_en[UCC_IE_RX] & (rx_level_i >= rx_eff);
        src_tmo  = state.int_en[UCC_IE_RX] & state.fifo_en & rx_timeout_i;
        src_tx   = state.int_en[UCC_IE_TX] & state.tx_pend;
        src_mdm  = state.int_en[UCC_IE_MODEM] & modem_change_i;
        src_flow = enh & state.int_en[UCC_IE_FLOW]
                   & (state.flow_pend | state.spec_pend);  // [R3] [R4]
        src_chg  = enh & ((state.int_en[UCC_IE_CTS] & state.cts_pend)
                   | (state.int_en[UCC_IE_RTS] & state.rts_pend));  // [R5]

        // Fixed priority, highest first
        if (src_line)  // [R21] [R2]
            cause = UCC_CAUSE_LINE;
        else if (src_rx)
            cause = UCC_CAUSE_RX;
        else if (src_tmo)
            cause = UCC_CAUSE_TIMEOUT;
        else if (src_tx)
            cause = UCC_CAUSE_TX;
        else if (src_mdm)
            cause = UCC_CAUSE_MODEM;
        else if (src_flow)
            cause = UCC_CAUSE_FLOW;
        else if (src_chg)
            cause = UCC_CAUSE_CHANGE;
        else
            cause = UCC_CAUSE_NONE;  // [R1]
        cause_byte = {{2{state.fifo_en}}, cause};  // [R6]

        // Register read mux
        rbyte = UCC_RST_BYTE;
        if (wb_adr_i == UCC_ADR_CAUSE)
            rbyte = cause_byte;
        else if (wb_adr_i == UCC_ADR_FORMAT)
            rbyte = state.format;
        else if (wb_adr_i == UCC_ADR_INT_EN)
            rbyte = state.int_en;
        else if (wb_adr_i == UCC_ADR_ENHANCED)
            rbyte = state.enhanced;
        else if (wb_adr_i == UCC_ADR_FEATURE)
            rbyte = state.feature;
        else if (wb_adr_i == UCC_ADR_TX_PROG)
            rbyte = {1'b0, state.tx_prog};
        else if (wb_adr_i == UCC_ADR_RX_PROG)
            rbyte = {1'b0, state.rx_prog};
        else if (wb_adr_i == UCC_ADR_LAST_FC)
            rbyte = {7'h00, state.last_xoff};  // [R3]

        // Every request is answered, unmapped or not, one cycle later
        next_state.ack   = req;
        next_state.rdata = req ? {24'h000000, rbyte} : 32'h00000000;
        rd_cause = req & ~wb_we_i & (wb_adr_i == UCC_ADR_CAUSE);

        next_state.rx_clr = 1'b0;
        next_state.tx_clr = 1'b0;

        // Register writes
        if (wr && wb_adr_i == UCC_ADR_SETUP)
        begin
            next_state.fifo_en = wbyte[UCC_SETUP_EN];  // [R7]
            if (wbyte[UCC_SETUP_EN])  // [R7]
            begin
                next_state.rx_clr     = wbyte[UCC_SETUP_RX_CLR];  // [R8]
                next_state.tx_clr     = wbyte[UCC_SETUP_TX_CLR];  // [R9]
                next_state.block_mode = wbyte[UCC_SETUP_BLOCK];  // [R10]
                next_state.rx_sel     = wbyte[UCC_SETUP_RX_LSB +: 2];
                if (enh)  // [R12]
                    next_state.tx_sel = wbyte[UCC_SETUP_TX_LSB +: 2];
            end
        end
        else if (wr && wb_adr_i == UCC_ADR_FORMAT)
            next_state.format = wbyte;
        else if (wr && wb_adr_i == UCC_ADR_INT_EN)
            next_state.int_en = wbyte;
        else if (wr && wb_adr_i == UCC_ADR_ENHANCED)
            next_state.enhanced = wbyte;
        else if (wr && wb_adr_i == UCC_ADR_FEATURE)
            next_state.feature = wbyte;  // [R13]
        else if (wr && wb_adr_i == UCC_ADR_TX_PROG)
            next_state.tx_prog = wbyte[6:0];  // [R14]
        else if (wr && wb_adr_i == UCC_ADR_RX_PROG)
            next_state.rx_prog = wbyte[6:0];  // [R14]

        // Transmit ready: crossing below trigger, or emptied after a low reload
        tx_fall  = (state.tx_prev >= tx_eff) && (tx_level_i < tx_eff);  // [R11]
        tx_empty = (state.tx_prev != 7'h00) && (tx_level_i == 7'h00)
                   && ~state.tx_above;  // [R11]
        next_state.tx_prev = tx_level_i;
        if (tx_level_i == 7'h00)
            next_state.tx_above = 1'b0;
        else if (tx_level_i > tx_eff)
            next_state.tx_above = 1'b1;

        // Set wins over clear on every sticky flag
        if (tx_fall || tx_empty)
            next_state.tx_pend = 1'b1;  // [R11]
        else if (rd_cause)
            next_state.tx_pend = 1'b0;  // [R22]

        if (enh && flow_match_i)
        begin
            next_state.flow_pend = 1'b1;  // [R3]
            next_state.last_xoff = flow_is_xoff_i;  // [R3]
        end
        else if (rd_cause)
            next_state.flow_pend = 1'b0;  // [R3]

        if (enh && special_i)
            next_state.spec_pend = 1'b1;  // [R4]
        else if (rd_cause || rx_char_i)
            next_state.spec_pend = 1'b0;  // [R4]

        // Flow line edges, three-stage synchronised
        next_state.cts_sync = {state.cts_sync[1:0], cts_pin_i};
        next_state.rts_sync = {state.rts_sync[1:0], rts_pin_i};
        cts_new = settle(state.cts_sync, state.cts_st);
        rts_new = settle(state.rts_sync, state.rts_st);
        next_state.cts_st = cts_new;
        next_state.rts_st = rts_new;
        if (enh && cts_new && !state.cts_st)
            next_state.cts_pend = 1'b1;  // [R5]
        else if (modem_read_i)
            next_state.cts_pend = 1'b0;
        if (enh && rts_new && !state.rts_st)
            next_state.rts_pend = 1'b1;  // [R5]
        else if (modem_read_i)
            next_state.rts_pend = 1'b0;

        // Registered copies for the outputs
        next_state.rx_trig   = rx_eff;  // [R15]
        next_state.tx_trig   = tx_eff;  // [R15]
        next_state.data_bits = UCC_MIN_BITS
                               + {2'b00, state.format[UCC_FMT_LEN_LSB +: 2]};  // [R16]
        next_state.stop_half = state.format[UCC_FMT_STOP]
                               & (state.format[UCC_FMT_LEN_LSB +: 2] == 2'h0);  // [R17]
        next_state.stop_two  = state.format[UCC_FMT_STOP]
                               & (state.format[UCC_FMT_LEN_LSB +: 2] != 2'h0);  // [R17]
        next_state.par_en    = state.format[UCC_FMT_PAR_EN];  // [R18]
        if (!state.format[UCC_FMT_FORCE])
            next_state.par_kind = state.format[UCC_FMT_EVEN]
                                  ? UCC_PAR_EVEN : UCC_PAR_ODD;  // [R19]
        else
            next_state.par_kind = state.format[UCC_FMT_EVEN]
                                  ? UCC_PAR_SPACE : UCC_PAR_MARK;  // [R20]
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state            <= '0;
            state.rx_trig    <= UCC_RST_PROG;  // [R15]
            state.tx_trig    <= UCC_RST_PROG;  // [R15]
            state.rx_prog    <= UCC_RST_PROG;
            state.tx_prog    <= UCC_RST_PROG;
            state.data_bits  <= UCC_MIN_BITS;  // [R16]
            state.format     <= UCC_RST_BYTE;
            state.par_kind   <= UCC_PAR_ODD;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign wb_dat_o      = state.rdata;
    assign wb_ack_o      = state.ack;
    assign fifo_enable_o = state.fifo_en;
    assign rx_fifo_clr_o = state.rx_clr;
    assign tx_fifo_clr_o = state.tx_clr;
    assign rx_trigger_o  = state.rx_trig;
    assign tx_trigger_o  = state.tx_trig;
    assign data_bits_o   = state.data_bits;
    assign stop_half_o   = state.stop_half;
    assign stop_two_o    = state.stop_two;
    assign parity_en_o   = state.par_en;
    assign parity_kind_o = state.par_kind;

endmodule

// file: dv/ucc_dp_model.sv
// FIFO count model beside the channel.
// Assumes bench loads; a clear pulse wins.
module ucc_dp_model (
    input  wire logic       clk_i,      // Channel clock
    input  wire logic       rst_i,      // Synchronous reset
    input  wire logic       rx_clr_i,   // Receive clear pulse
    input  wire logic       tx_clr_i,   // Transmit clear pulse
    input  wire logic       load_i,     // Load both counts
    input  wire logic [6:0] rx_load_i,  // Receive count to load
    input  wire logic [6:0] tx_load_i,  // Transmit count to load
    output logic      [6:0] rx_level_o, // Receive FIFO count
    output logic      [6:0] tx_level_o  // Transmit FIFO count
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || rx_clr_i)
            rx_level_o <= 7'h00;
        else if (load_i)
            rx_level_o <= rx_load_i;
        if (rst_i || tx_clr_i)
            tx_level_o <= 7'h00;
        else if (load_i)
            tx_level_o <= tx_load_i;
    end
endmodule

// file: dv/ucc_channel_ctrl_asserts.sv
// Port checker for the channel control block.
// Assumes masters idle a cycle between requests.
module ucc_channel_ctrl_asserts
    import ucc_pkg::*;
(
    input wire logic        clk_i,         // Clock
    input wire logic        rst_i,         // Reset
    input wire logic        wb_cyc_i,      // Cycle
    input wire logic        wb_stb_i,      // Strobe
    input wire logic        wb_we_i,       // Write
    input wire logic [7:0]  wb_adr_i,      // Address
    input wire logic [3:0]  wb_sel_i,      // Selects
    input wire logic [31:0] wb_dat_i,      // Write data
    input wire logic [31:0] wb_dat_o,      // Read data
    input wire logic        wb_ack_o,      // Acknowledge
    input wire logic        fifo_enable_o, // FIFOs on
    input wire logic        rx_fifo_clr_o, // Receive clear
    input wire logic        tx_fifo_clr_o, // Transmit clear
    input wire logic [6:0]  rx_trigger_o,  // Receive trigger
    input wire logic [6:0]  tx_trigger_o,  // Transmit trigger
    input wire logic [3:0]  data_bits_o,   // Data bits
    input wire logic        stop_half_o,   // 1.5 stop bits
    input wire logic        stop_two_o     // 2 stop bits
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic set_wr;
    assign set_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == UCC_ADR_SETUP;
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("long ack");
    a_enable_set: assert property (set_wr && wb_dat_i[0] |-> fifo_enable_o)
        else $error("enable not set");
    a_enable_clear: assert property (set_wr && !wb_dat_i[0] |-> !fifo_enable_o)
        else $error("enable not cleared");
    a_rx_clear_pulse: assert property (set_wr && wb_dat_i[1:0] == 2'h3
        |-> rx_fifo_clr_o ##1 !rx_fifo_clr_o) else $error("no rx clear");
    a_tx_clear_pulse: assert property (set_wr && wb_dat_i[2] && wb_dat_i[0]
        |-> tx_fifo_clr_o ##1 !tx_fifo_clr_o) else $error("no tx clear");
    a_clear_gated: assert property (set_wr && !wb_dat_i[0]
        |=> (!rx_fifo_clr_o && !tx_fifo_clr_o) [*2]) else $error("clear while off");
    a_cause_fifo_bits: assert property (wb_ack_o && !wb_we_i && wb_adr_i == UCC_ADR_CAUSE
        |-> wb_dat_o[7:6] == {2{fifo_enable_o}}) else $error("cause 7:6 wrong");
    a_trigger_off: assert property (!fifo_enable_o && !$past(fifo_enable_o)
        |-> rx_trigger_o == 7'h01 && tx_trigger_o == 7'h01) else $error("trigger not 1");
    a_stop_half: assert property (stop_half_o |-> data_bits_o == 4'h5 && !stop_two_o)
        else $error("half stop wrong");
    a_stop_two: assert property (stop_two_o |-> data_bits_o != 4'h5 && !stop_half_o)
        else $error("two stop wrong");
    c_cause_pend: cover property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 && !wb_dat_o[0]);
    c_rx_clear: cover property (rx_fifo_clr_o);
    c_stop_half: cover property (stop_half_o);
endmodule
bind ucc_channel_ctrl ucc_channel_ctrl_asserts i_chk (.*);

// file: dv/testbench.sv
// Self-checking bench for the channel control block.
// Assumes a Wishbone slave that answers each request once.
module testbench
    import ucc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
    logic line_err = 1'b0, mchg = 1'b0, xoff = 1'b0, cts = 1'b0;
    logic [5:0] ev = 6'h00;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic ack, fen, rclr, tclr, shalf, stwo, pen;
    logic [6:0] rtrig, ttrig, rlev, tlev, rld = 7'h00, tld = 7'h00;
    logic [3:0] dbits;
    logic [1:0] pkind;
    int fail_count = 0, tests_run = 0;
    logic [6:0] rx_tab [4][4] = '{'{7'h01, 7'h04, 7'h08, 7'h0E}, '{7'h08, 7'h10, 7'h18, 7'h1C},
        '{7'h08, 7'h10, 7'h38, 7'h3C}, '{4{7'h33}}};
    logic [6:0] tx_tab [4][4] = '{'{4{7'h01}}, '{7'h10, 7'h08, 7'h18, 7'h1E},
        '{7'h08, 7'h10, 7'h20, 7'h38}, '{4{7'h25}}};
    always #2.5 clk_i = ~clk_i;
    ucc_channel_ctrl i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .rx_level_i(rlev), .tx_level_i(tlev), .rx_timeout_i(ev[5]), .line_err_i(line_err),
        .modem_change_i(mchg), .modem_read_i(ev[0]), .rx_char_i(ev[1]), .flow_match_i(ev[2]),
        .flow_is_xoff_i(xoff), .special_i(ev[3]), .cts_pin_i(cts), .rts_pin_i(1'b0),
        .fifo_enable_o(fen), .rx_fifo_clr_o(rclr), .tx_fifo_clr_o(tclr), .rx_trigger_o(rtrig),
        .tx_trigger_o(ttrig), .data_bits_o(dbits), .stop_half_o(shalf), .stop_two_o(stwo),
        .parity_en_o(pen), .parity_kind_o(pkind));
    ucc_dp_model i_dp (.clk_i, .rst_i, .rx_clr_i(rclr), .tx_clr_i(tclr), .load_i(ev[4]),
        .rx_load_i(rld), .tx_load_i(tld), .rx_level_o(rlev), .tx_level_o(tlev));
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 40)
        begin
            n++;
            @(posedge clk_i);
        end
        if (n >= 40)
            fail_count++;
        rd = rdat;
        cyc <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        chk(rd, {24'h0, exp});
    endtask
    task automatic rc(input logic [7:0] exp);
        rdc(UCC_ADR_CAUSE, exp);
    endtask
    task automatic pulse(input int b);
        @(posedge clk_i);
        ev[b] <= 1'b1;
        @(posedge clk_i);
        ev[b] <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic lev(input logic [6:0] r, input logic [6:0] t);
        rld <= r;
        tld <= t;
        pulse(4);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        close_out();
    end
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({rtrig, ttrig, dbits}, {7'h01, 7'h01, 4'h5});
        rc(8'h01);
        rdc(8'h3C, 8'h00);
        rdc(UCC_ADR_SETUP, 8'h00);
        for (int i = 0; i < 64; i++)
        begin
            wb(1'b1, UCC_ADR_FORMAT, i[7:0]);
            rdc(UCC_ADR_FORMAT, i[7:0]);
            chk({dbits, shalf, stwo, pen, pkind}, {4'h5 + {2'h0, i[1:0]}, i[2] && i[1:0] == 2'h0,
                i[2] && i[1:0] != 2'h0, i[3], i[5:4]});
        end
        wb(1'b1, UCC_ADR_TX_PROG, 8'h25);
        wb(1'b1, UCC_ADR_RX_PROG, 8'h33);
        wb(1'b1, UCC_ADR_ENHANCED, 8'h10);
        for (int t = 0; t < 4; t++)
            for (int s = 0; s < 4; s++)
            begin
                wb(1'b1, UCC_ADR_FEATURE, {t[1:0], 6'h00});
                wb(1'b1, UCC_ADR_SETUP, {s[1:0], s[1:0], 4'h1});
                repeat (3) @(posedge clk_i);
                chk({rtrig, ttrig}, {rx_tab[t][s], tx_tab[t][s]});
            end
        wb(1'b1, UCC_ADR_FEATURE, 8'h40);
        wb(1'b1, UCC_ADR_SETUP, 8'h01);
        wb(1'b1, UCC_ADR_ENHANCED, 8'h00);
        wb(1'b1, UCC_ADR_SETUP, 8'h39);
        repeat (3) @(posedge clk_i);
        chk({rtrig, ttrig}, {7'h08, 7'h10});
        wb(1'b1, UCC_ADR_ENHANCED, 8'h10);
        lev(7'h09, 7'h09);
        wb(1'b1, UCC_ADR_SETUP, 8'h07);
        repeat (3) @(posedge clk_i);
        chk({rlev, tlev}, 14'h0);
        lev(7'h03, 7'h03);
        wb(1'b1, UCC_ADR_SETUP, 8'h06);
        repeat (3) @(posedge clk_i);
        chk({fen, rlev, tlev, rtrig, ttrig}, {1'b0, 7'h03, 7'h03, 7'h01, 7'h01});
        rc(8'h01);
        wb(1'b1, UCC_ADR_FEATURE, 8'h00);
        wb(1'b1, UCC_ADR_SETUP, 8'h01);
        wb(1'b1, UCC_ADR_INT_EN, 8'hAF);
        lev(7'h00, 7'h05);
        rc(8'hC1);
        lev(7'h00, 7'h00);
        rc(8'hC2);
        rc(8'hC1);
        lev(7'h00, 7'h05);
        lev(7'h00, 7'h00);
        line_err <= 1'b1;
        rc(8'hC6);
        line_err <= 1'b0;
        lev(7'h01, 7'h00);
        rc(8'hC4);
        lev(7'h00, 7'h00);
        mchg <= 1'b1;
        rc(8'hC0);
        mchg <= 1'b0;
        ev[5] <= 1'b1;
        rc(8'hCC);
        ev[5] <= 1'b0;
        xoff <= 1'b1;
        pulse(2);
        rc(8'hD0);
        rc(8'hC1);
        rdc(UCC_ADR_LAST_FC, 8'h01);
        pulse(3);
        rc(8'hD0);
        pulse(3);
        pulse(1);
        rc(8'hC1);
        cts <= 1'b1;
        repeat (6) @(posedge clk_i);
        rc(8'hE0);
        pulse(0);
        rc(8'hC1);
        close_out();
    end
endmodule
